//--- rtl/lp_clock_ctrl.sv
// lp_clock_ctrl: low-power mode, clock gating, PLL multiplier, settle wait, watchdog
// assumes one main oscillator clock; register port from the CPU on the same clock
// Functional notes
// - watchdog is a 2-bit counter stepped by timebase carries, with control and reset
// - timebase runs from main oscillator regardless of main/PLL select
// - timebase raises periodic interval interrupts
// - six modes; all but PLL run are low-power
// - main run and main sleep use oscillator divided by two, PLL halted
// - sleep modes stop only the CPU clock
// - clock-only mode keeps only the timebase running
// - stop mode halts the oscillator, state is kept
// - intermittent mode gates CPU clock on accesses, peripherals stay full speed
// - PLL multiplier 1 to 4 from two-bit select
// - settle wait after stop chosen by two-bit field
`default_nettype none
`include "lpclk_defines.svh"
module lp_clock_ctrl
  import lpclk_pkg::*;
(
  input wire logic sys_clk_i,
  input wire logic arst_n_i,
  input wire logic ce_i,
  input wire logic [2:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [7:0] reg_rdata_o,
  input wire logic wake_i,
  input wire logic cpu_access_i,
  output logic cpu_clk_en_o,
  output logic periph_clk_en_o,
  output logic tb_clk_en_o,
  output logic pll_en_o,
  output logic osc_en_o,
  output logic div2_sel_o,
  output logic [2:0] pll_mult_o,
  output logic pin_hold_o,
  output logic wdog_reset_o,
  output logic irq_o
);
  ////////////////////////////////////////////////////////////////////////////////
  reg_req_t req;
  clk_ctrl_t clk_r;
  clk_ctrl_t clk_nxt;
  op_mode_t mode_r;
  op_mode_t mode_nxt;
  logic [7:0] lpmode_r;
  logic [7:0] clksel_r;
  logic [7:0] tbctl_r;
  logic [3:0] wdctl_r;
  logic [2:0] irq_stat_r;
  logic [2:0] irq_mask_r;
  logic [1:0] wd_cnt_r;
  logic [1:0] gate_cnt_r;
  logic [4:0] settle_cnt_r;
  logic [7:0] wd_rst_cnt_r;
  logic [7:0] rdata_nxt;
  logic wake_s1_r;
  logic wake_s2_r;
  logic wr_lp;
  logic wr_ck;
  logic stop_req;
  logic sleep_req;
  logic main_sel;
  logic tb_run;
  logic tb_clear;
  logic tb_tick;
  logic wd_carry;
  logic wd_clear;
  logic wd_fire;
  logic settle_done;
  logic [`TB_WIDTH-1:0] tb_count;
  logic [2:0] irq_set;

  assign req = '{addr: reg_addr_i, wdata: reg_wdata_i, wr: reg_wr_i, rd: reg_rd_i};

  function automatic logic wr_hit(input reg_req_t r, input logic [2:0] a);
    wr_hit = r.wr && (r.addr == a);
  endfunction : wr_hit

  assign wr_lp = wr_hit(req, `ADDR_LPMODE);
  assign wr_ck = wr_hit(req, `ADDR_CLKSEL);
  assign stop_req = wr_lp && reg_wdata_i[`LP_STOP_BIT];
  assign sleep_req = wr_lp && reg_wdata_i[`LP_SLEEP_BIT];
  assign main_sel = clksel_r[`CK_MCS_BIT];
  assign wd_clear = wr_hit(req, `ADDR_WDOG) && reg_wdata_i[`WD_CLEAR_BIT];

  ////////////////////////////////////////////////////////////////////////////////
  // wake pin synchroniser
  always_ff @(posedge sys_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      wake_s1_r <= 1'b0;
      wake_s2_r <= 1'b0;
    end
    else if (ce_i)
    begin
      wake_s1_r <= wake_i;
      wake_s2_r <= wake_s1_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // control registers
  always_ff @(posedge sys_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      lpmode_r <= `RST_LPMODE;
      clksel_r <= `RST_CLKSEL;
      tbctl_r <= `RST_TBCTL;
      wdctl_r <= 4'h0;
      irq_mask_r <= 3'h0;
    end
    else if (ce_i)
    begin
      if (wr_lp)
      begin
        lpmode_r[`LP_PINHOLD_BIT] <= reg_wdata_i[`LP_PINHOLD_BIT];
        lpmode_r[`LP_CG_LSB +: 2] <= reg_wdata_i[`LP_CG_LSB +: 2];
      end
      if (wr_ck)
      begin
        clksel_r[`CK_WS_LSB +: 2] <= reg_wdata_i[`CK_WS_LSB +: 2];
        clksel_r[`CK_MCS_BIT] <= reg_wdata_i[`CK_MCS_BIT];
        clksel_r[`CK_CS_LSB +: 2] <= reg_wdata_i[`CK_CS_LSB +: 2];
      end
      clksel_r[`CK_MCM_BIT] <= main_sel;
      if (wr_hit(req, `ADDR_TBCTL))
        tbctl_r <= reg_wdata_i;
      if (wr_hit(req, `ADDR_WDOG) && reg_wdata_i[`WD_ENABLE_BIT])
      begin
        wdctl_r[`WD_ENABLE_BIT] <= 1'b1;
        wdctl_r[`WD_SEL_LSB +: 2] <= reg_wdata_i[`WD_SEL_LSB +: 2];
      end
      if (wr_hit(req, `ADDR_IRQ_MASK))
        irq_mask_r <= reg_wdata_i[2:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // operating mode machine
  always_comb
  begin
    mode_nxt = mode_r;
    unique case (mode_r)
      MODE_PLL_RUN, MODE_MAIN_RUN:
        if (stop_req)
          mode_nxt = tbctl_r[`TB_CLOCKONLY_BIT] ? MODE_CLOCK_ONLY : MODE_STOP;
        else if (sleep_req)
          mode_nxt = main_sel ? MODE_MAIN_SLEEP : MODE_PLL_SLEEP;
        else
          mode_nxt = main_sel ? MODE_MAIN_RUN : MODE_PLL_RUN;
      MODE_PLL_SLEEP, MODE_MAIN_SLEEP:
        if (wake_s2_r || (|(irq_stat_r & irq_mask_r)))
          mode_nxt = main_sel ? MODE_MAIN_RUN : MODE_PLL_RUN;
      MODE_CLOCK_ONLY:
        if (wake_s2_r || (|(irq_stat_r & irq_mask_r)))
          mode_nxt = main_sel ? MODE_MAIN_RUN : MODE_PLL_RUN;
      MODE_STOP:
        if (wake_s2_r)
          mode_nxt = MODE_SETTLE;
      MODE_SETTLE:
        if (settle_done)
          mode_nxt = main_sel ? MODE_MAIN_RUN : MODE_PLL_RUN;
      default:
        mode_nxt = MODE_PLL_RUN;
    endcase
  end

  always_ff @(posedge sys_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      mode_r <= MODE_MAIN_RUN;
    else if (ce_i)
      mode_r <= mode_nxt;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // settle wait: 2^(ws+1) interval ticks of the timebase
  assign tb_run = (mode_r != MODE_STOP);
  assign tb_clear = (mode_r == MODE_STOP) && wake_s2_r;
  assign settle_done = (settle_cnt_r == (5'h02 << clksel_r[`CK_WS_LSB +: 2]));

  always_ff @(posedge sys_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      settle_cnt_r <= 5'h00;
    else if (ce_i)
    begin
      if (mode_r != MODE_SETTLE)
        settle_cnt_r <= 5'h00;
      else if (tb_tick && !settle_done)
        settle_cnt_r <= settle_cnt_r + 5'h01;
    end
  end

  timebase_timer u_tb (
    .sys_clk_i(sys_clk_i),
    .arst_n_i(arst_n_i),
    .ce_i(ce_i),
    .run_i(tb_run),
    .clear_i(tb_clear),
    .int_sel_i(tbctl_r[`TB_SEL_LSB +: 2]),
    .wd_sel_i(wdctl_r[`WD_SEL_LSB +: 2]),
    .count_o(tb_count),
    .int_tick_o(tb_tick),
    .wd_carry_o(wd_carry)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // clock enables
  always_comb
  begin
    clk_nxt.pll_mult = 3'({1'b0, clksel_r[`CK_CS_LSB +: 2]}) + 3'h1;
    clk_nxt.div2_sel = (mode_r == MODE_MAIN_RUN) || (mode_r == MODE_MAIN_SLEEP);
    clk_nxt.pll_en = !clk_nxt.div2_sel && (mode_r != MODE_STOP) && (mode_r != MODE_SETTLE)
                     && (mode_r != MODE_CLOCK_ONLY);
    clk_nxt.osc_en = (mode_r != MODE_STOP);
    clk_nxt.tb_en = (mode_r != MODE_STOP);
    clk_nxt.periph_en = (mode_r == MODE_PLL_RUN) || (mode_r == MODE_MAIN_RUN)
                        || (mode_r == MODE_PLL_SLEEP) || (mode_r == MODE_MAIN_SLEEP);
    clk_nxt.cpu_en = ((mode_r == MODE_PLL_RUN) || (mode_r == MODE_MAIN_RUN))
                     && !(cpu_access_i && (gate_cnt_r != 2'h0));
  end

  // intermittent gating: hold cpu off for cg count after each access
  always_ff @(posedge sys_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      gate_cnt_r <= 2'h0;
    else if (ce_i)
    begin
      if (gate_cnt_r != 2'h0)
        gate_cnt_r <= gate_cnt_r - 2'h1;
      else if (cpu_access_i)
        gate_cnt_r <= lpmode_r[`LP_CG_LSB +: 2];
    end
  end

  always_ff @(posedge sys_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      clk_r <= '{cpu_en: 1'b1, periph_en: 1'b1, tb_en: 1'b1, pll_en: 1'b0, osc_en: 1'b1,
                 div2_sel: 1'b1, pll_mult: 3'h1};
    else if (ce_i)
      clk_r <= clk_nxt;
  end

  assign cpu_clk_en_o = clk_r.cpu_en;
  assign periph_clk_en_o = clk_r.periph_en;
  assign tb_clk_en_o = clk_r.tb_en;
  assign pll_en_o = clk_r.pll_en;
  assign osc_en_o = clk_r.osc_en;
  assign div2_sel_o = clk_r.div2_sel;
  assign pll_mult_o = clk_r.pll_mult;
  assign pin_hold_o = lpmode_r[`LP_PINHOLD_BIT];

  ////////////////////////////////////////////////////////////////////////////////
  // watchdog
  assign wd_fire = wdctl_r[`WD_ENABLE_BIT] && wd_carry && (wd_cnt_r == 2'h3) && !wd_clear;

  always_ff @(posedge sys_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      wd_cnt_r <= 2'h0;
    else if (ce_i)
    begin
      if (wd_clear)
        wd_cnt_r <= 2'h0;
      else if (wdctl_r[`WD_ENABLE_BIT] && wd_carry)
        wd_cnt_r <= wd_cnt_r + 2'h1;
    end
  end

  always_ff @(posedge sys_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      wd_rst_cnt_r <= 8'h00;
    else if (ce_i)
    begin
      if (wd_fire)
        wd_rst_cnt_r <= `WD_RESET_CYCLES;
      else if (wd_rst_cnt_r != 8'h00)
        wd_rst_cnt_r <= wd_rst_cnt_r - 8'h01;
    end
  end

  assign wdog_reset_o = (wd_rst_cnt_r != 8'h00);

  ////////////////////////////////////////////////////////////////////////////////
  // interrupts: set wins over write-one-to-clear
  assign irq_set = {wake_s2_r && (mode_r == MODE_STOP), wd_fire, tb_tick};

  always_ff @(posedge sys_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      irq_stat_r <= 3'h0;
    else if (ce_i)
    begin
      if (wr_hit(req, `ADDR_IRQ_STAT))
        irq_stat_r <= (irq_stat_r & ~reg_wdata_i[2:0]) | irq_set;
      else
        irq_stat_r <= irq_stat_r | irq_set;
    end
  end

  assign irq_o = |(irq_stat_r & irq_mask_r);

  ////////////////////////////////////////////////////////////////////////////////
  // read port
  always_comb
  begin
    unique case (reg_addr_i)
      `ADDR_LPMODE: rdata_nxt = {2'b00, lpmode_r[`LP_PINHOLD_BIT], 2'b11, lpmode_r[2:1], 1'b0};
      `ADDR_CLKSEL: rdata_nxt = {1'b1, main_sel, clksel_r[5:4], 1'b1, clksel_r[2:0]};
      `ADDR_WDOG: rdata_nxt = {4'h0, wdctl_r[3:2], wd_cnt_r};
      `ADDR_TBCTL: rdata_nxt = {tbctl_r[7:3], tb_count[`TB_WIDTH-1 -: 3]};
      `ADDR_IRQ_STAT: rdata_nxt = {5'h00, irq_stat_r};
      `ADDR_IRQ_MASK: rdata_nxt = {5'h00, irq_mask_r};
      default: rdata_nxt = 8'h00;
    endcase
  end

  always_ff @(posedge sys_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      reg_rdata_o <= 8'h00;
    else if (ce_i)
      reg_rdata_o <= reg_rd_i ? rdata_nxt : 8'h00;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // checks
  a_stop_osc_off: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
    ce_i && mode_r == MODE_STOP |=> !osc_en_o) else $error("osc running in stop");
  a_sleep_cpu_only: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
    ce_i && (mode_r == MODE_PLL_SLEEP || mode_r == MODE_MAIN_SLEEP) |=> !cpu_clk_en_o && periph_clk_en_o)
    else $error("sleep gating wrong");
  a_main_div_two: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
    ce_i && mode_r == MODE_MAIN_RUN |=> div2_sel_o && !pll_en_o) else $error("main mode clocks wrong");
  a_clock_only: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
    ce_i && mode_r == MODE_CLOCK_ONLY |=> tb_clk_en_o && !periph_clk_en_o && !cpu_clk_en_o)
    else $error("clock-only gating wrong");
  a_pll_mult: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
    ce_i |=> pll_mult_o == 3'($past(clksel_r[1:0])) + 3'h1) else $error("pll multiplier wrong");
  a_settle_hold: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
    ce_i && mode_r == MODE_SETTLE |=> !cpu_clk_en_o && !periph_clk_en_o) else $error("clock during settle");
  a_wd_reset: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
    ce_i && wd_fire |=> wdog_reset_o [*8]) else $error("watchdog reset too short");
  a_wd_step: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
    ce_i && wdctl_r[2] && wd_carry && !wd_clear |=> wd_cnt_r == $past(wd_cnt_r) + 2'h1)
    else $error("watchdog count not stepped");
  a_tb_irq: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
    ce_i && tb_tick |=> irq_stat_r[0]) else $error("interval flag lost");
  a_modes_lp: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
    ce_i && (mode_r == MODE_PLL_RUN || mode_r == MODE_MAIN_RUN) && stop_req && !tbctl_r[2] |=> mode_r == MODE_STOP)
    else $error("stop not entered");
  a_gate_cpu: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
    ce_i && (mode_r == MODE_PLL_RUN || mode_r == MODE_MAIN_RUN) && cpu_access_i && gate_cnt_r != 2'h0
    |=> !cpu_clk_en_o && periph_clk_en_o)
    else $error("intermittent gating wrong");
  a_tb_free: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
    ce_i && mode_r != MODE_STOP && !tb_clear |=> tb_count == $past(tb_count) + 18'h1)
    else $error("timebase stalled");
endmodule : lp_clock_ctrl
`default_nettype wire

//--- pkg/lpclk_defines.svh
// lpclk_defines.svh: offsets, field positions, reset values and timing counts
// assumes inclusion by the clock controller package users only
`ifndef LPCLK_DEFINES_SVH
`define LPCLK_DEFINES_SVH
`define ADDR_LPMODE 3'h0
`define ADDR_CLKSEL 3'h1
`define ADDR_WDOG 3'h2
`define ADDR_TBCTL 3'h3
`define ADDR_IRQ_STAT 3'h4
`define ADDR_IRQ_MASK 3'h5
`define RST_LPMODE 8'h18
`define RST_CLKSEL 8'hFC
`define RST_TBCTL 8'h00
`define LP_STOP_BIT 7
`define LP_SLEEP_BIT 6
`define LP_PINHOLD_BIT 5
`define LP_RESET_BIT 4
`define LP_CG_LSB 1
`define CK_MCM_BIT 6
`define CK_WS_LSB 4
`define CK_MCS_BIT 2
`define CK_CS_LSB 0
`define WD_ENABLE_BIT 2
`define WD_CLEAR_BIT 3
`define WD_SEL_LSB 0
`define TB_CLOCKONLY_BIT 2
`define TB_SEL_LSB 0
`define IRQ_TB_BIT 0
`define IRQ_WD_BIT 1
`define IRQ_WAKE_BIT 2
`define TB_WIDTH 18
`define WD_RESET_CYCLES 8'h10
`endif

//--- pkg/lpclk_pkg.sv
// lpclk_pkg: types of the low-power clock controller
// assumes the defines header is compiled alongside
`default_nettype none
package lpclk_pkg;
  typedef enum logic [2:0] {
    MODE_PLL_RUN = 3'b000,
    MODE_PLL_SLEEP = 3'b001,
    MODE_MAIN_RUN = 3'b010,
    MODE_MAIN_SLEEP = 3'b011,
    MODE_CLOCK_ONLY = 3'b100,
    MODE_STOP = 3'b101,
    MODE_SETTLE = 3'b110
  } op_mode_t;

  typedef struct packed {
    logic cpu_en;
    logic periph_en;
    logic tb_en;
    logic pll_en;
    logic osc_en;
    logic div2_sel;
    logic [2:0] pll_mult;
  } clk_ctrl_t;

  typedef struct packed {
    logic [2:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } reg_req_t;
endpackage : lpclk_pkg
`default_nettype wire

//--- rtl/timebase_timer.sv
// timebase_timer: 18-bit free counter with interval tap and watchdog carry
// assumes enable from the controller; runs on the main oscillator clock
`default_nettype none
`include "lpclk_defines.svh"
module timebase_timer
  import lpclk_pkg::*;
(
  input wire logic sys_clk_i,
  input wire logic arst_n_i,
  input wire logic ce_i,
  input wire logic run_i,
  input wire logic clear_i,
  input wire logic [1:0] int_sel_i,
  input wire logic [1:0] wd_sel_i,
  output logic [`TB_WIDTH-1:0] count_o,
  output logic int_tick_o,
  output logic wd_carry_o
);
  logic [`TB_WIDTH-1:0] cnt_r;
  logic [`TB_WIDTH-1:0] cnt_nxt;

  // carry out of tap bit: low bits all ones
  function automatic logic tap_carry(input logic [`TB_WIDTH-1:0] c, input logic [4:0] b);
    logic [`TB_WIDTH-1:0] m;
    m = (`TB_WIDTH'(1) << b) - `TB_WIDTH'(1);
    tap_carry = ((c & m) == m);
  endfunction : tap_carry

  assign cnt_nxt = cnt_r + `TB_WIDTH'(1);
  assign count_o = cnt_r;

  always_ff @(posedge sys_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      cnt_r <= '0;
    else if (ce_i)
    begin
      if (clear_i)
        cnt_r <= '0;
      else if (run_i)
        cnt_r <= cnt_nxt;
    end
  end

  // interval taps 2^12, 2^14, 2^16, 2^18, watchdog taps 2^14..2^17
  always_comb
  begin
    int_tick_o = ce_i && run_i && !clear_i && tap_carry(cnt_r, 5'(12 + 2 * int_sel_i));
    wd_carry_o = ce_i && run_i && !clear_i && tap_carry(cnt_r, 5'(14 + wd_sel_i));
  end
endmodule : timebase_timer
`default_nettype wire

//--- dv/far_side_model.sv
// far_side_model: CPU core and peripherals that consume the gated clocks
// assumes the bench commands accesses and wake; counts gated cycles during accesses
`default_nettype none
module far_side_model
(
  input wire logic sys_clk_i,
  input wire logic arst_n_i,
  input wire logic cpu_clk_en_i,
  input wire logic periph_clk_en_i,
  input wire logic access_req_i,
  input wire logic wake_req_i,
  input wire logic count_clr_i,
  output logic cpu_access_o,
  output logic wake_o,
  output logic [15:0] cpu_gaps_o,
  output logic [15:0] periph_gaps_o
);
  timeunit 1ns;
  timeprecision 1ps;
  ////////////////////////////////////////////////////////////////////////////
  // core bus access on the clock edge; wake is an asynchronous pin level
  always_ff @(posedge sys_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      cpu_access_o <= 1'h0;
    end
    else
    begin
      cpu_access_o <= access_req_i;
    end
  end
  assign wake_o = wake_req_i;
  ////////////////////////////////////////////////////////////////////////////
  // cycles without a clock while the core is accessing
  always_ff @(posedge sys_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      cpu_gaps_o <= 16'h0000;
      periph_gaps_o <= 16'h0000;
    end
    else if (count_clr_i)
    begin
      cpu_gaps_o <= 16'h0000;
      periph_gaps_o <= 16'h0000;
    end
    else if (cpu_access_o)
    begin
      cpu_gaps_o <= cpu_gaps_o + {15'h0000, !cpu_clk_en_i};
      periph_gaps_o <= periph_gaps_o + {15'h0000, !periph_clk_en_i};
    end
  end
endmodule : far_side_model
`default_nettype wire

//--- dv/lp_clock_ctrl_tb.sv
// lp_clock_ctrl_tb: register-driven tests of modes, gating, settle wait, irq and watchdog
// assumes one 100 MHz clock and the far side model on the access and wake pins
`default_nettype none
module lp_clock_ctrl_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk_i, arst_n_i, reg_wr, reg_rd, access_req, wake_req, count_clr;
  logic [2:0] reg_addr;
  logic [7:0] reg_wdata, d, outs;
  logic [2:0] pll_mult_o;
  logic [7:0] rdata;
  logic cpu_access, wake, cpu_clk_en_o, periph_clk_en_o, tb_clk_en_o, pll_en_o, osc_en_o;
  logic div2_sel_o, pin_hold_o, wdog_reset_o, irq_o;
  logic [15:0] cpu_gaps, periph_gaps;
  int fail_count, samples_checked, i, n, bad;
  assign outs = {cpu_clk_en_o, periph_clk_en_o, tb_clk_en_o, pll_en_o, osc_en_o, div2_sel_o, pin_hold_o, wdog_reset_o};
  lp_clock_ctrl i_dut (.sys_clk_i(sys_clk_i), .arst_n_i(arst_n_i), .ce_i(1'h1), .reg_addr_i(reg_addr),
    .reg_wdata_i(reg_wdata), .reg_wr_i(reg_wr), .reg_rd_i(reg_rd), .reg_rdata_o(rdata), .wake_i(wake),
    .cpu_access_i(cpu_access), .cpu_clk_en_o(cpu_clk_en_o), .periph_clk_en_o(periph_clk_en_o),
    .tb_clk_en_o(tb_clk_en_o), .pll_en_o(pll_en_o), .osc_en_o(osc_en_o), .div2_sel_o(div2_sel_o),
    .pll_mult_o(pll_mult_o), .pin_hold_o(pin_hold_o), .wdog_reset_o(wdog_reset_o), .irq_o(irq_o));
  far_side_model i_far (.sys_clk_i(sys_clk_i), .arst_n_i(arst_n_i), .cpu_clk_en_i(cpu_clk_en_o),
    .periph_clk_en_i(periph_clk_en_o), .access_req_i(access_req), .wake_req_i(wake_req),
    .count_clr_i(count_clr), .cpu_access_o(cpu_access), .wake_o(wake), .cpu_gaps_o(cpu_gaps),
    .periph_gaps_o(periph_gaps));
  ////////////////////////////////////////////////////////////////////////////
  task automatic conclude;
    if (fail_count == 0 && samples_checked > 0)
    begin
      $display("DONE - PASS");
    end
    else
    begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : conclude
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic wr(input logic [2:0] a, input logic [7:0] v);
    @(posedge sys_clk_i);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'h1;
    @(posedge sys_clk_i);
    reg_wr <= 1'h0;
  endtask : wr
  task automatic rd(input logic [2:0] a, output logic [7:0] v);
    @(posedge sys_clk_i);
    reg_addr <= a;
    reg_rd <= 1'h1;
    @(posedge sys_clk_i);
    reg_rd <= 1'h0;
    @(negedge sys_clk_i);
    v = rdata;
  endtask : rd
  task automatic cycles(input int k);
    repeat (k) @(posedge sys_clk_i);
    @(negedge sys_clk_i);
  endtask : cycles
  function automatic logic pick(input int sel);
    return sel == 0 ? cpu_clk_en_o : (sel == 1 ? irq_o : (sel == 2 ? osc_en_o : wdog_reset_o));
  endfunction : pick
  task automatic wait_sig(input int sel, input logic lvl, input int bound);
    int k;
    for (k = 0; k < bound; k++)
    begin
      @(negedge sys_clk_i);
      if (pick(sel) === lvl)
        break;
    end
    if (k >= bound)
    begin
      fail_count++;
      conclude();
    end
  endtask : wait_sig
  task automatic wake_cpu;
    @(posedge sys_clk_i);
    wake_req <= 1'h1;
    wait_sig(0, 1'h1, 20);
    @(posedge sys_clk_i);
    wake_req <= 1'h0;
    cycles(3);
  endtask : wake_cpu
  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    sys_clk_i = 1'h0;
    forever #5 sys_clk_i = ~sys_clk_i;
  end
  initial
  begin
    fail_count = 0;
    samples_checked = 0;
    arst_n_i = 1'h0;
    {reg_wr, reg_rd, access_req, wake_req, count_clr} = 5'h00;
    reg_addr = 3'h0;
    reg_wdata = 8'h00;
    repeat (6) @(posedge sys_clk_i);
    arst_n_i <= 1'h1;
    cycles(1);
    check(outs, 8'hEC);
    check({7'h00, irq_o}, 8'h00);
    rd(3'h0, d);
    check(d, 8'h18);
    rd(3'h1, d);
    check(d, 8'hFC);
    rd(3'h7, d);
    check(d, 8'h00);
    for (i = 0; i < 4; i++)
    begin
      wr(3'h1, 8'hFC | i[7:0]);
      cycles(2);
      check({5'h00, pll_mult_o}, i[7:0] + 8'h01);
      rd(3'h1, d);
      check(d, 8'hFC | i[7:0]);
    end
    wr(3'h0, 8'h20);
    cycles(2);
    check({7'h00, pin_hold_o}, 8'h01);
    rd(3'h0, d);
    check(d, 8'h38);
    wr(3'h0, 8'h00);
    wr(3'h1, 8'hC4);
    cycles(2);
    check(outs, 8'hEC);
    rd(3'h1, d);
    check(d, 8'hCC);
    wr(3'h0, 8'h40);
    cycles(2);
    check(outs, 8'h6C);
    wake_cpu();
    check(outs, 8'hEC);
    wr(3'h3, 8'h04);
    wr(3'h0, 8'h80);
    cycles(2);
    check(outs, 8'h28);
    wake_cpu();
    check(outs, 8'hEC);
    wr(3'h3, 8'h00);
    wr(3'h4, 8'h07);
    wr(3'h0, 8'h80);
    cycles(2);
    check(outs & 8'hF8, 8'h00);
    @(posedge sys_clk_i);
    wake_req <= 1'h1;
    wait_sig(2, 1'h1, 50);
    @(posedge sys_clk_i);
    wake_req <= 1'h0;
    bad = 0;
    for (n = 0; n < 8000; n++)
    begin
      @(negedge sys_clk_i);
      if (cpu_clk_en_o !== 1'h0 || periph_clk_en_o !== 1'h0)
        bad++;
    end
    check({7'h00, bad != 0}, 8'h00);
    wait_sig(0, 1'h1, 1000);
    cycles(2);
    check(outs, 8'hEC);
    rd(3'h4, d);
    check(d & 8'h04, 8'h04);
    for (i = 0; i < 4; i++)
    begin
      wr(3'h0, {5'h00, i[1:0], 1'h0});
      @(posedge sys_clk_i);
      count_clr <= 1'h1;
      @(posedge sys_clk_i);
      count_clr <= 1'h0;
      access_req <= 1'h1;
      repeat (12) @(posedge sys_clk_i);
      access_req <= 1'h0;
      cycles(2);
      check({7'h00, cpu_gaps != 16'h0000}, {7'h00, i != 0});
      check(periph_gaps[7:0], 8'h00);
    end
    wr(3'h0, 8'h00);
    wr(3'h4, 8'h07);
    wr(3'h5, 8'h01);
    wait_sig(1, 1'h1, 8400);
    rd(3'h4, d);
    check(d & 8'h01, 8'h01);
    wr(3'h5, 8'h00);
    cycles(1);
    check({7'h00, irq_o}, 8'h00);
    wr(3'h5, 8'h01);
    cycles(1);
    check({7'h00, irq_o}, 8'h01);
    wr(3'h4, 8'h01);
    cycles(1);
    check({7'h00, irq_o}, 8'h00);
    rd(3'h4, d);
    check(d & 8'h01, 8'h00);
    wr(3'h2, 8'h04);
    d = 8'h00;
    for (n = 0; n < 20000 && d[1:0] == 2'h0; n++)
      rd(3'h2, d);
    check(d & 8'h07, 8'h05);
    check({7'h00, wdog_reset_o}, 8'h00);
    wait_sig(3, 1'h1, 49300);
    for (n = 1; n < 40; n++)
    begin
      @(negedge sys_clk_i);
      if (wdog_reset_o !== 1'h1)
        break;
    end
    check(n[7:0], 8'h10);
    rd(3'h4, d);
    check(d & 8'h02, 8'h02);
    wr(3'h2, 8'h0C);
    rd(3'h2, d);
    check(d & 8'h03, 8'h00);
    conclude();
  end
endmodule : lp_clock_ctrl_tb
`default_nettype wire
